// >>> rtl/dpwdt_pkg.sv
package dpwdt_pkg;
    // ==========================================
    // Register map (word offsets x4)
    localparam logic [7:0] DPWDT_CTRL_OFS = 8'h00;
    localparam logic [7:0] DPWDT_RANGE_OFS = 8'h04;
    localparam logic [7:0] DPWDT_COUNT_OFS = 8'h08;
    localparam logic [7:0] DPWDT_RESTART_OFS = 8'h0C;
    localparam logic [7:0] DPWDT_STATUS_OFS = 8'h10;
    localparam logic [7:0] DPWDT_EOI_OFS = 8'h14;
    // ==========================================
    // Field positions
    localparam int DPWDT_CTRL_EN_BIT = 0;
    localparam int DPWDT_CTRL_RMOD_BIT = 1;
    localparam int DPWDT_RANGE_TOP_LSB = 0;
    localparam int DPWDT_RANGE_INIT_LSB = 4;
    localparam int DPWDT_COUNTER_W = 32;
    localparam int DPWDT_PERIOD_BASE = 16;
    localparam logic [7:0] DPWDT_RESTART_KEY = 8'h76;
    localparam logic [3:0] DPWDT_RANGE_RST = 4'h0;
    // ==========================================
    // Device-side operations
    typedef enum logic [2:0] {
        DPWDT_OP_NONE,
        DPWDT_OP_CTRL,
        DPWDT_OP_RANGE,
        DPWDT_OP_RESTART,
        DPWDT_OP_EOI
    } dpwdt_op_t;

    function automatic logic [31:0] dpwdt_period(input logic [3:0] sel);
        dpwdt_period = 32'hFFFFFFFF >> (5'(DPWDT_PERIOD_BASE) - {1'b0, sel});
    endfunction
endpackage

// >>> rtl/dpwdt_if.sv
`timescale 1ns/1ps
interface dpwdt_if;
    import dpwdt_pkg::*;
    dpwdt_op_t op;
    logic [31:0] wdata;
    logic [31:0] count;
    logic enabled;
    logic rmod;
    logic second;
    logic [7:0] range;
    logic irq;
    logic rst_req;
    logic pause;

    modport dev (
        input op, wdata, pause,
        output count, enabled, rmod, second, range, irq, rst_req
    );
    modport ctl (
        output op, wdata, pause,
        input count, enabled, rmod, second, range, irq, rst_req
    );
endinterface

// >>> rtl/dpwdt_dev.sv
`timescale 1ns/1ps
// ==========================================
module dpwdt_dev (
    input wire logic clk_i, // free running peripheral clock
    input wire logic rst_i, // synchronous reset
    dpwdt_if.dev bus // controller side
);
    import dpwdt_pkg::*;

    // ==========================================
    // Timer states
    typedef enum logic [1:0] {
        DPWDT_ST_OFF,
        DPWDT_ST_FIRST,
        DPWDT_ST_SECOND
    } dpwdt_state_t;

    dpwdt_state_t state_q;
    dpwdt_state_t state_d;
    logic rmod_q;
    logic irq_q;
    logic irq_d;
    logic rst_req_q;
    logic rst_req_d;
    logic [3:0] top_q;
    logic [3:0] init_q;
    logic [DPWDT_COUNTER_W-1:0] cnt_q;
    logic [DPWDT_COUNTER_W-1:0] cnt_d;
    logic enabled;
    logic start;
    logic restart;
    logic at_zero;

    // ==========================================
    // Access decoding
    function automatic logic is_start(input dpwdt_op_t op, input logic [31:0] data);
        is_start = op == DPWDT_OP_CTRL && data[DPWDT_CTRL_EN_BIT];
    endfunction

    function automatic logic is_key(input dpwdt_op_t op, input logic [31:0] data);
        is_key = op == DPWDT_OP_RESTART && data[7:0] == DPWDT_RESTART_KEY;
    endfunction

    assign enabled = state_q != DPWDT_ST_OFF;
    assign start = !enabled && is_start(bus.op, bus.wdata);
    // Keyed write and interrupt-clear read both restart
    assign restart = enabled && (is_key(bus.op, bus.wdata)
                                 || bus.op == DPWDT_OP_EOI);
    // Pause also holds off a timeout
    assign at_zero = enabled && !bus.pause && cnt_q == '0;

    // ==========================================
    // State machine
    // Only a reset returns the timer to off
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DPWDT_ST_OFF: begin
                if (start) begin
                    state_d = DPWDT_ST_FIRST;
                end
            end
            DPWDT_ST_FIRST: begin
                if (restart) begin
                    state_d = DPWDT_ST_FIRST;
                end else if (at_zero && rmod_q) begin
                    state_d = DPWDT_ST_SECOND;
                end
            end
            DPWDT_ST_SECOND: begin
                if (restart) begin
                    state_d = DPWDT_ST_FIRST;
                end
            end
            default: begin
                state_d = DPWDT_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= DPWDT_ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================
    // Control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rmod_q <= 1'b0;
        end else if (bus.op == DPWDT_OP_CTRL) begin
            rmod_q <= bus.wdata[DPWDT_CTRL_RMOD_BIT];
        end
    end

    // Both selectors are taken in one write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            top_q <= DPWDT_RANGE_RST;
            init_q <= DPWDT_RANGE_RST;
        end else if (bus.op == DPWDT_OP_RANGE) begin
            top_q <= bus.wdata[DPWDT_RANGE_TOP_LSB +: 4];
            init_q <= bus.wdata[DPWDT_RANGE_INIT_LSB +: 4];
        end
    end

    // ==========================================
    // Counter
    // Counting resumes from the restart period after a timeout
    always_comb begin
        cnt_d = cnt_q;
        if (start) begin
            cnt_d = dpwdt_period(init_q);
        end else if (!enabled) begin
            cnt_d = cnt_q;
        end else if (restart) begin
            cnt_d = dpwdt_period(top_q);
        end else if (bus.pause) begin
            cnt_d = cnt_q;
        end else if (cnt_q == '0) begin
            cnt_d = dpwdt_period(top_q);
        end else begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ==========================================
    // Response
    always_comb begin
        irq_d = irq_q;
        if (at_zero && !restart && rmod_q && state_q != DPWDT_ST_SECOND) begin
            irq_d = 1'b1;
        end else if (bus.op == DPWDT_OP_EOI) begin
            irq_d = 1'b0;
        end
    end

    // Restart on the zero cycle wins
    always_comb begin
        rst_req_d = rst_req_q;
        if (at_zero && !restart && (!rmod_q || state_q == DPWDT_ST_SECOND)) begin
            rst_req_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Sticky until the reset manager resets the block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_req_q <= 1'b0;
        end else begin
            rst_req_q <= rst_req_d;
        end
    end

    // ==========================================
    // Outputs
    assign bus.count = cnt_q;
    assign bus.enabled = enabled;
    assign bus.rmod = rmod_q;
    assign bus.second = state_q == DPWDT_ST_SECOND;
    assign bus.range = {init_q, top_q};
    assign bus.irq = irq_q;
    assign bus.rst_req = rst_req_q;
endmodule

// >>> rtl/dpwdt_ctl.sv
`timescale 1ns/1ps
module dpwdt_ctl (
    input wire logic clk_i, // clock
    input wire logic rst_i, // synchronous reset
    input wire logic [31:0] wb_adr_i, // Wishbone address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    input wire logic wb_we_i, // write enable
    input wire logic [3:0] wb_sel_i, // byte selects
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    output logic wb_ack_o, // acknowledge
    input wire logic pause_i, // debug pause from system manager
    output logic irq_o, // interrupt to processor
    output logic rst_req_o, // reset request to reset manager
    dpwdt_if.ctl wd // watchdog device
);
    import dpwdt_pkg::*;

    logic ack_q;
    logic [31:0] rdat_q;
    logic take;
    dpwdt_op_t op_d;

    assign take = wb_cyc_i && wb_stb_i && !ack_q;

    // ==========================================
    // Decode
    always_comb begin
        op_d = DPWDT_OP_NONE;
        if (take) begin
            if (wb_we_i && wb_sel_i[0]) begin
                unique case (wb_adr_i[7:0])
                    DPWDT_CTRL_OFS: op_d = DPWDT_OP_CTRL;
                    DPWDT_RANGE_OFS: op_d = DPWDT_OP_RANGE;
                    DPWDT_RESTART_OFS: op_d = DPWDT_OP_RESTART;
                    default: op_d = DPWDT_OP_NONE;
                endcase
            end else if (!wb_we_i && wb_adr_i[7:0] == DPWDT_EOI_OFS) begin
                op_d = DPWDT_OP_EOI;
            end
        end
    end

    assign wd.op = op_d;
    assign wd.wdata = wb_dat_i;
    assign wd.pause = pause_i;

    // ==========================================
    // Bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= take;
            if (take && !wb_we_i) begin
                unique case (wb_adr_i[7:0])
                    DPWDT_CTRL_OFS: rdat_q <= {30'h0, wd.rmod, wd.enabled};
                    DPWDT_RANGE_OFS: rdat_q <= {24'h0, wd.range};
                    DPWDT_COUNT_OFS: rdat_q <= wd.count;
                    DPWDT_STATUS_OFS: rdat_q <= {29'h0, wd.rst_req, wd.second, wd.irq};
                    default: rdat_q <= 32'h00000000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o = wd.irq;
    assign rst_req_o = wd.rst_req;
endmodule

// >>> tb/dpwdt_monitor.sv
`timescale 1ns/1ps
// ====
// Link checks
module dpwdt_monitor (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire dpwdt_pkg::dpwdt_op_t op, // op
    input wire logic [31:0] wdata, // data
    input wire logic [31:0] count, // count
    input wire logic enabled, // on
    input wire logic rmod, // mode
    input wire logic second, // stage
    input wire logic [7:0] range, // periods
    input wire logic irq, // irq
    input wire logic rst_req, // req
    input wire logic pause // hold
);
    import dpwdt_pkg::*;
    logic [31:0] tp;
    logic run;
    assign tp = 32'hFFFFFFFF >> (5'h10 - {1'b0, range[3:0]});
    assign run = enabled && !pause && op == DPWDT_OP_NONE;
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_start_load:
    assert property (op == DPWDT_OP_CTRL && wdata[0] && !enabled |=> enabled
        && count == 32'hFFFFFFFF >> (5'h10 - {1'b0, range[7:4]})) else $error("start");
    a_key_load:
    assert property (op == DPWDT_OP_RESTART && wdata[7:0] == DPWDT_RESTART_KEY && enabled |=> count == tp)
        else $error("key");
    a_count_step:
    assert property (enabled && !pause && count != 0 && (op == DPWDT_OP_NONE || op == DPWDT_OP_RESTART
        && wdata[7:0] != DPWDT_RESTART_KEY) |=> count == $past(count) - 1) else $error("step");
    a_pause_hold:
    assert property (enabled && pause && op == DPWDT_OP_NONE |=> $stable(count)) else $error("pause");
    a_stay_on:
    assert property (enabled |=> enabled) else $error("off");
    a_reset_off:
    assert property (disable iff (1'b0) rst_i |=> !enabled && !irq && !rst_req) else $error("reset");
    a_first_irq:
    assert property (run && rmod && !second && count == 0 |=> irq && second && !rst_req && count == tp)
        else $error("zero");
    a_eoi_clear:
    assert property (op == DPWDT_OP_EOI && enabled && count != 0 |=> !irq && !second) else $error("eoi");
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ====
// Bench
module tb_top;
    import dpwdt_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, pause = 1'b0, ack, irq, rreq;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, rd, c0;
    int err_count = 0, checked = 0;
    dpwdt_if wif();
    dpwdt_dev i_dpwdt_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(wif));
    dpwdt_ctl i_dpwdt_ctl (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i({24'h0, adr}), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .pause_i(pause),
        .irq_o(irq), .rst_req_o(rreq), .wd(wif));
    dpwdt_monitor i_dpwdt_monitor (.clk_i(clk_i), .rst_i(rst_i), .op(wif.op), .wdata(wif.wdata), .count(wif.count),
        .enabled(wif.enabled), .rmod(wif.rmod), .second(wif.second), .range(wif.range), .irq(wif.irq),
        .rst_req(wif.rst_req), .pause(wif.pause));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic ok);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: mismatch", $time);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        we <= w;
        dat <= d;
        cyc <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        chk(n == 2);
        @(posedge clk_i);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        wb(a, 1'b0, 32'h0);
        chk(rd >= lo && rd <= hi);
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic t_start();
        rchk(DPWDT_COUNT_OFS, 32'h0, 32'h0);
        rchk(DPWDT_STATUS_OFS, 32'h0, 32'h0);
        rchk(8'h40, 32'h0, 32'h0);
        wb(DPWDT_RANGE_OFS, 1'b1, 32'h10);
        wb(DPWDT_CTRL_OFS, 1'b1, 32'h3);
        rchk(DPWDT_COUNT_OFS, 32'h1FFD0, 32'h1FFFF);
        c0 = rd;
        wb(DPWDT_RESTART_OFS, 1'b1, 32'h75);
        wb(DPWDT_CTRL_OFS, 1'b1, 32'h2);
        rchk(DPWDT_COUNT_OFS, 32'h1FF00, c0 - 32'h1);
        wb(DPWDT_RESTART_OFS, 1'b1, 32'h76);
        rchk(DPWDT_COUNT_OFS, 32'hFFD0, 32'hFFFF);
        pause <= 1'b1;
        @(posedge clk_i);
        wb(DPWDT_COUNT_OFS, 1'b0, 32'h0);
        c0 = rd;
        rchk(DPWDT_COUNT_OFS, c0, c0);
        pause <= 1'b0;
        $display("start test done");
    endtask
    task automatic t_timeout();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 70000) begin
            @(posedge clk_i);
            n++;
        end
        chk(irq === 1'b1 && rreq === 1'b0);
        rchk(DPWDT_STATUS_OFS, 32'h3, 32'h3);
        rchk(DPWDT_EOI_OFS, 32'h0, 32'h0);
        @(posedge clk_i);
        chk(irq === 1'b0);
        rchk(DPWDT_STATUS_OFS, 32'h0, 32'h0);
        rchk(DPWDT_COUNT_OFS, 32'hFF00, 32'hFFFF);
        $display("timeout test done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_start();
        t_timeout();
        end_sim();
    end
    initial begin
        #1000000;
        err_count++;
        end_sim();
    end
endmodule
